/* File: common/rst_seq_map.svh */
// Constants of the reset and configuration sequencer: clock rate,
// reset and load timing, serial memory link figures, port fields.
// Assumes it is included by bare name wherever a figure is needed.
`ifndef RST_SEQ_MAP_SVH
`define RST_SEQ_MAP_SVH
// ==========================================================
// Clock
`define CLK_PERIOD_NS 8
`define CLK_FREQ_HZ 125000000
// ==========================================================
// Serial memory link
`define SCL_FREQ_HZ 58600
`define SCL_QTR_CYC (`CLK_FREQ_HZ / (`SCL_FREQ_HZ * 4))
`define EE_DEV_ADDR 7'h50
`define EE_START_ADDR 8'h00
`define EE_BYTES 256
// ==========================================================
// Reset and sequence timing
`define T_RST_MIN_NS 1000
`define RST_MIN_CYC ((`T_RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_STAB_US 500
`define T_LOAD_MS 50
`define T_REQ_MS 5
// ==========================================================
// Upstream reset effects
`define PRT_WIDTH 4
`define PRT_USB_RST_HI 3
`define PRT_USB_RST_LO 2
`define DEV_ADDR_RESET 7'h00
`define DEV_CFG_NONE 8'h00
`endif

/* File: common/rst_seq_pkg.sv */
// Types of the reset and configuration sequencer.
// Assumes nothing of its surroundings; used by scoped name only.
package rst_seq_pkg;
   // ==========================================================
   // Start-up sequence states
   typedef enum logic [4:0] {
      SEQ_HOLD   = 5'h01,
      SEQ_STAB   = 5'h02,
      SEQ_LOAD   = 5'h04,
      SEQ_ATTACH = 5'h08,
      SEQ_RUN    = 5'h10
   } seq_state_t;
   // ==========================================================
   // Serial link engine states
   typedef enum logic [5:0] {
      I2C_IDLE  = 6'h01,
      I2C_START = 6'h02,
      I2C_TX    = 6'h04,
      I2C_RX    = 6'h08,
      I2C_STOP  = 6'h10,
      I2C_DONE  = 6'h20
   } i2c_state_t;
endpackage : rst_seq_pkg

/* File: design/eeprom_seq_reader.sv */
// Serial memory reader: master that fetches the configuration image
// with one addressed sequential read.
// Assumes sdaIn is already synchronised and abort is synchronous.
`timescale 1ns/1ns
`include "rst_seq_map.svh"
module eeprom_seq_reader #(
   parameter int QTR_CYC = `SCL_QTR_CYC,
   parameter logic [6:0] DEV_ADDR = `EE_DEV_ADDR,
   parameter int NBYTES = `EE_BYTES,
   localparam int AW = $clog2(NBYTES)
) (
   input wire logic ref_clk,
   input wire logic abort,
   input wire logic start,
   input wire logic sdaIn,
   output logic sclDrvLow,
   output logic sdaDrvLow,
   output logic byteValid,
   output logic [AW-1:0] byteAddr,
   output logic [7:0] byteData,
   output logic done,
   output logic error,
   output logic busy
);
   localparam int DW = $clog2(QTR_CYC);
   rst_seq_pkg::i2c_state_t state_q;
   logic [DW-1:0] div_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [1:0] stage_q;
   logic [AW-1:0] cnt_q;
   logic sclHi_q, sdaHi_q, nack_q, err_q, done_q, bv_q;
   logic [7:0] bd_q;
   logic [AW-1:0] ba_q;
   // ==========================================================
   // Quarter-bit timebase and bit decode
   wire tick = (div_q == DW'(QTR_CYC - 1));
   wire lastBit = (bit_q == 4'h8);
   wire lastByte = (cnt_q == AW'(NBYTES - 1));
   wire txLevel = lastBit ? 1'b1 : sh_q[7];
   wire rxLevel = lastBit ? lastByte : 1'b1; // Nack only the final byte
   // Divider idles so every frame starts on a full quarter
   always_ff @(posedge ref_clk) begin
      if (abort || state_q == rst_seq_pkg::I2C_IDLE) div_q <= '0;
      else div_q <= tick ? '0 : div_q + 1'b1;
   end
   // ==========================================================
   // Bus engine: we own the clock and every start and stop
   always_ff @(posedge ref_clk) begin
      bv_q <= 1'b0;
      done_q <= 1'b0;
      if (abort) begin
         state_q <= rst_seq_pkg::I2C_IDLE;
         sclHi_q <= 1'b1;
         sdaHi_q <= 1'b1;
         ph_q <= 2'h0;
         err_q <= 1'b0;
      end else if (state_q == rst_seq_pkg::I2C_IDLE) begin
         if (start) begin
            state_q <= rst_seq_pkg::I2C_START;
            ph_q <= 2'h0;
            stage_q <= 2'h0;
            cnt_q <= '0;
            err_q <= 1'b0;
         end
      end else if (tick) begin
         ph_q <= ph_q + 2'h1;
         case (state_q)
            rst_seq_pkg::I2C_START: begin
               case (ph_q)
                  2'h0: sdaHi_q <= 1'b1;
                  2'h1: sclHi_q <= 1'b1;
                  2'h2: sdaHi_q <= 1'b0;
                  default: begin
                     sclHi_q <= 1'b0;
                     state_q <= rst_seq_pkg::I2C_TX;
                     sh_q <= {DEV_ADDR, stage_q == 2'h2};
                     bit_q <= 4'h0;
                  end
               endcase
            end
            rst_seq_pkg::I2C_TX: begin
               case (ph_q)
                  2'h0: sdaHi_q <= txLevel;
                  2'h1: sclHi_q <= 1'b1;
                  2'h2: nack_q <= sdaIn;
                  default: begin
                     sclHi_q <= 1'b0;
                     bit_q <= bit_q + 4'h1;
                     sh_q <= {sh_q[6:0], 1'b0};
                     if (lastBit && nack_q) begin
                        err_q <= 1'b1;
                        state_q <= rst_seq_pkg::I2C_STOP;
                     end else if (lastBit) begin
                        bit_q <= 4'h0;
                        stage_q <= stage_q + 2'h1;
                        // Address write, word address, restart, then read
                        case (stage_q)
                           2'h0: sh_q <= `EE_START_ADDR;
                           2'h1: state_q <= rst_seq_pkg::I2C_START;
                           default: state_q <= rst_seq_pkg::I2C_RX;
                        endcase
                     end
                  end
               endcase
            end
            rst_seq_pkg::I2C_RX: begin
               case (ph_q)
                  2'h0: sdaHi_q <= rxLevel;
                  2'h1: sclHi_q <= 1'b1;
                  2'h2: if (!lastBit) sh_q <= {sh_q[6:0], sdaIn};
                  default: begin
                     sclHi_q <= 1'b0;
                     bit_q <= bit_q + 4'h1;
                     if (lastBit) begin
                        bv_q <= 1'b1;
                        bd_q <= sh_q;
                        ba_q <= cnt_q;
                        bit_q <= 4'h0;
                        cnt_q <= cnt_q + 1'b1;
                        if (lastByte) state_q <= rst_seq_pkg::I2C_STOP;
                     end
                  end
               endcase
            end
            rst_seq_pkg::I2C_STOP: begin
               case (ph_q)
                  2'h0: sdaHi_q <= 1'b0;
                  2'h1: sclHi_q <= 1'b1;
                  2'h2: sdaHi_q <= 1'b1;
                  default: state_q <= rst_seq_pkg::I2C_DONE;
               endcase
            end
            default: begin
               done_q <= 1'b1;
               state_q <= rst_seq_pkg::I2C_IDLE;
            end
         endcase
      end
   end
   // Open-drain: a high level is released, never driven
   assign sclDrvLow = ~sclHi_q;
   assign sdaDrvLow = ~sdaHi_q;
   assign byteValid = bv_q;
   assign byteAddr = ba_q;
   assign byteData = bd_q;
   assign done = done_q;
   assign error = err_q;
   assign busy = (state_q != rst_seq_pkg::I2C_IDLE);
endmodule : eeprom_seq_reader

/* File: design/reset_and_eeprom_config_sequencer.sv */
// Reset and start-up sequencer of a hub and card-reader controller:
// three reset sources, reset effects, configuration load, attach.
// Assumes pins arrive unsynchronised and hub-side strobes on ref_clk.
`timescale 1ns/1ns
`include "rst_seq_map.svh"
module reset_and_eeprom_config_sequencer #(
   parameter int STAB_CYC = `T_STAB_US * 1000 / `CLK_PERIOD_NS,
   parameter int LOAD_MAX_CYC = `T_LOAD_MS * 1000000 / `CLK_PERIOD_NS,
   parameter int REQ_MAX_CYC = `T_REQ_MS * 1000000 / `CLK_PERIOD_NS,
   parameter int CFG_BYTES = `EE_BYTES,
   localparam int AW = $clog2(CFG_BYTES),
   localparam int PW = `PRT_WIDTH
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic external_hw_reset_low,
   input wire logic usbBusReset,
   input wire logic defaultCfgSel,
   input wire logic sdaIn,
   output logic sclOut,
   output logic sclOe,
   output logic sdaOut,
   output logic sdaOe,
   output logic cfgWrEn,
   output logic [AW-1:0] cfgWrAddr,
   output logic [7:0] cfgWrData,
   output logic cfgUseDefault,
   output logic cfgLoaded,
   output logic eeError,
   output logic oscEnable,
   output logic pllEnable,
   output logic phyEnable,
   output logic usbAttach,
   output logic coreReset,
   input wire logic [PW-1:0] portPowerReq,
   input wire logic [PW-1:0] portEnableReq,
   output logic [PW-1:0] port_power_switch_ctl,
   output logic [PW-1:0] downstreamPortEn,
   input wire logic setAddrStrobe,
   input wire logic [6:0] setAddrValue,
   input wire logic setConfigStrobe,
   input wire logic [7:0] setConfigValue,
   output logic [6:0] deviceAddress,
   output logic [7:0] deviceConfig,
   input wire logic suspendReq,
   input wire logic resumeReq,
   output logic suspended,
   output logic ttFlush,
   input wire logic hostReqStart,
   input wire logic hostReqDone,
   output logic reqBusy,
   output logic reqForceDone
);
   localparam int CW = $clog2(LOAD_MAX_CYC + 1);
   localparam int RW = $clog2(REQ_MAX_CYC + 1);
   localparam int LW = $clog2(`RST_MIN_CYC + 1);
   // Counter has reached its last cycle; shared by every timer here
   function automatic logic atLimit(input logic [31:0] cnt, input int lim);
      atLimit = (cnt >= 32'(lim - 1));
   endfunction : atLimit

   // ==========================================================
   // Pin synchronisers
   // Bit 0 reset pin, 1 upstream reset, 2 default strap, 3 data line
   logic [3:0] meta_q, sync_q;
   logic usbRstPrev_q;
   always_ff @(posedge ref_clk) begin
      meta_q <= {sdaIn, defaultCfgSel, usbBusReset, external_hw_reset_low};
      sync_q <= meta_q;
   end
   wire pinLow = ~sync_q[0];
   wire usbRstLvl = sync_q[1];
   wire dfltSel = sync_q[2];
   wire sdaSync = sync_q[3];

   // ==========================================================
   // External reset qualification
   logic [LW-1:0] lowCnt_q;
   logic hwRst_q;
   // Shorter pulses float the link but leave the device running
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !pinLow) lowCnt_q <= '0;
      else if (!hwRst_q) lowCnt_q <= lowCnt_q + 1'b1;
   end
   // Power-on reset and a qualified pin reset act alike
   always_ff @(posedge ref_clk) begin
      if (!rst_n) hwRst_q <= 1'b1;
      else if (!pinLow) hwRst_q <= 1'b0;
      else if (atLimit(32'(lowCnt_q), `RST_MIN_CYC)) hwRst_q <= 1'b1;
   end
   wire usbRst = usbRstLvl && !hwRst_q;

   // ==========================================================
   // Start-up sequence
   rst_seq_pkg::seq_state_t state_q;
   logic [CW-1:0] seqCnt_q;
   logic rdStart_q, rdAbort_q, useDflt_q, loaded_q, attach_q, eeErr_q;
   wire rdDone, rdErr, rdValid;
   wire [AW-1:0] rdAddr;
   wire [7:0] rdData;
   wire stabDone = atLimit(32'(seqCnt_q), STAB_CYC);
   wire loadLate = atLimit(32'(seqCnt_q), LOAD_MAX_CYC);
   wire inRun = (state_q == rst_seq_pkg::SEQ_RUN);
   always_ff @(posedge ref_clk) begin
      rdStart_q <= 1'b0;
      rdAbort_q <= 1'b0;
      if (hwRst_q) begin
         state_q <= rst_seq_pkg::SEQ_HOLD;
         seqCnt_q <= '0;
         useDflt_q <= 1'b0;
         loaded_q <= 1'b0;
         attach_q <= 1'b0;
         eeErr_q <= 1'b0;
      end else begin
         seqCnt_q <= seqCnt_q + 1'b1;
         case (state_q)
            rst_seq_pkg::SEQ_HOLD: begin
               state_q <= rst_seq_pkg::SEQ_STAB;
               seqCnt_q <= '0;
            end
            rst_seq_pkg::SEQ_STAB: begin
               // Oscillator and PLL settle before the link moves
               if (stabDone) begin
                  state_q <= rst_seq_pkg::SEQ_LOAD;
                  seqCnt_q <= '0;
                  useDflt_q <= dfltSel;
                  rdStart_q <= !dfltSel;
               end
            end
            rst_seq_pkg::SEQ_LOAD: begin
               if (useDflt_q || rdDone) begin
                  state_q <= rst_seq_pkg::SEQ_ATTACH;
                  // A nacked read has sent its stop; a slow one is cut off below
                  {eeErr_q, useDflt_q} <= {rdErr, useDflt_q || rdErr};
               end else if (loadLate) begin
                  rdAbort_q <= 1'b1;
                  eeErr_q <= 1'b1;
                  useDflt_q <= 1'b1;
                  state_q <= rst_seq_pkg::SEQ_ATTACH;
               end
            end
            rst_seq_pkg::SEQ_ATTACH: begin
               loaded_q <= 1'b1;
               attach_q <= 1'b1;
               state_q <= rst_seq_pkg::SEQ_RUN;
            end
            rst_seq_pkg::SEQ_RUN: seqCnt_q <= '0;
            default: state_q <= rst_seq_pkg::SEQ_HOLD;
         endcase
      end
   end

   // ==========================================================
   // Serial memory reader and pin drive
   wire rdAbortAll = !rst_n || pinLow || rdAbort_q || hwRst_q;
   wire sclLow, sdaLow;
   eeprom_seq_reader #(
      .NBYTES(CFG_BYTES)
   ) u_reader (
      .ref_clk(ref_clk),
      .abort(rdAbortAll),
      .start(rdStart_q),
      .sdaIn(sdaSync),
      .sclDrvLow(sclLow),
      .sdaDrvLow(sdaLow),
      .byteValid(rdValid),
      .byteAddr(rdAddr),
      .byteData(rdData),
      .done(rdDone),
      .error(rdErr),
      .busy()
   );
   // Pin low floats both lines so a programmer can own the memory
   assign sclOut = 1'b0;
   assign sdaOut = 1'b0;
   assign sclOe = sclLow && !pinLow && !hwRst_q;
   assign sdaOe = sdaLow && !pinLow && !hwRst_q;
   // Image bytes only count while a load is really in progress
   assign cfgWrEn = rdValid && (state_q == rst_seq_pkg::SEQ_LOAD);
   assign cfgWrAddr = rdAddr;
   assign cfgWrData = rdData;

   // ==========================================================
   // Clock, transceiver and core reset controls
   logic osc_q, phy_q, core_q;
   always_ff @(posedge ref_clk) begin
      osc_q <= !hwRst_q;
      phy_q <= !hwRst_q;
      core_q <= hwRst_q;
   end
   assign oscEnable = osc_q;
   assign pllEnable = osc_q;
   assign phyEnable = phy_q;
   assign coreReset = core_q;
   assign cfgUseDefault = useDflt_q;
   assign cfgLoaded = loaded_q;
   assign eeError = eeErr_q;
   assign usbAttach = attach_q;

   // ==========================================================
   // Downstream ports
   logic [PW-1:0] pwr_q, pen_q;
   wire [PW-1:0] usbKeep = ~(PW'(3) << `PRT_USB_RST_LO);
   always_ff @(posedge ref_clk) begin
      if (hwRst_q) begin
         pwr_q <= '0;
         pen_q <= '0;
      end else begin
         pwr_q <= portPowerReq & {PW{inRun}} & (usbRst ? usbKeep : {PW{1'b1}});
         pen_q <= portEnableReq & {PW{inRun}};
      end
   end
   assign port_power_switch_ctl = pwr_q;
   assign downstreamPortEn = pen_q;

   // ==========================================================
   // Upstream device state
   logic [6:0] addr_q;
   logic [7:0] cfg_q;
   logic susp_q, flush_q;
   always_ff @(posedge ref_clk) begin
      usbRstPrev_q <= usbRst;
      flush_q <= usbRst && !usbRstPrev_q;
      if (hwRst_q || usbRst) begin
         addr_q <= `DEV_ADDR_RESET;
         cfg_q <= `DEV_CFG_NONE;
         susp_q <= 1'b0;
      end else begin
         if (setAddrStrobe) addr_q <= setAddrValue;
         if (setConfigStrobe) cfg_q <= setConfigValue;
         if (resumeReq) susp_q <= 1'b0;
         else if (suspendReq) susp_q <= 1'b1;
      end
   end
   assign deviceAddress = addr_q;
   assign deviceConfig = cfg_q;
   assign suspended = susp_q;
   assign ttFlush = flush_q;

   // ==========================================================
   // Host request watchdog
   logic [RW-1:0] reqCnt_q;
   logic reqBusy_q, reqForce_q;
   wire reqLate = atLimit(32'(reqCnt_q), REQ_MAX_CYC);
   // A stuck request is closed out rather than left to the host
   always_ff @(posedge ref_clk) begin
      reqForce_q <= 1'b0;
      if (hwRst_q || usbRst) begin
         reqBusy_q <= 1'b0;
         reqCnt_q <= '0;
      end else if (hostReqStart) begin
         reqBusy_q <= 1'b1;
         reqCnt_q <= '0;
      end else if (reqBusy_q) begin
         reqCnt_q <= reqCnt_q + 1'b1;
         if (hostReqDone) reqBusy_q <= 1'b0;
         else if (reqLate) begin
            reqBusy_q <= 1'b0;
            reqForce_q <= 1'b1;
         end
      end
   end
   assign reqBusy = reqBusy_q;
   assign reqForceDone = reqForce_q;
endmodule : reset_and_eeprom_config_sequencer

/* File: test/reset_seq_chk.sv */
// Checker of the reset sequencer: reset effects, timing and start-up at the top ports.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ns
module reset_seq_chk #(
   parameter int STAB_CYC = 20,
   parameter int REQ_MAX_CYC = 50
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic external_hw_reset_low,
   input wire logic usbBusReset,
   input wire logic sclOe,
   input wire logic sdaOe,
   input wire logic cfgLoaded,
   input wire logic usbAttach,
   input wire logic coreReset,
   input wire logic oscEnable,
   input wire logic pllEnable,
   input wire logic phyEnable,
   input wire logic [3:0] port_power_switch_ctl,
   input wire logic [3:0] downstreamPortEn,
   input wire logic [6:0] deviceAddress,
   input wire logic [7:0] deviceConfig,
   input wire logic suspended,
   input wire logic ttFlush,
   input wire logic hostReqStart,
   input wire logic reqBusy
);
   // ==========================================================
   // Helper counts: pin low time, time since release, busy time
   logic [7:0] lowCnt_q;
   int relCnt_q;
   int busyCnt_q;
   always_ff @(posedge ref_clk) begin
      lowCnt_q <= (!rst_n || external_hw_reset_low) ? 8'h00 : lowCnt_q + {7'h00, lowCnt_q != 8'hFF};
      relCnt_q <= (!rst_n || coreReset) ? 0 : relCnt_q + (relCnt_q < STAB_CYC);
      busyCnt_q <= (!rst_n || !reqBusy || hostReqStart) ? 0 : busyCnt_q + 1;
   end
   // ==========================================================
   // Properties; the pin-low and release counters saturate so long runs never wrap
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_link_float: assert property (!external_hw_reset_low [*5] |-> !sclOe && !sdaOe)
      else $error("link driven while pin reset is low");
   a_hw_effects: assert property (lowCnt_q >= 8'h83 |-> coreReset && !oscEnable && !pllEnable && !phyEnable
      && port_power_switch_ctl == 4'h0 && downstreamPortEn == 4'h0 && deviceAddress == 7'h00)
      else $error("pin reset effects missing");
   a_pin_valid: assert property ($rose(coreReset) |-> lowCnt_q >= 8'h7D)
      else $error("pin reset taken before 1 us");
   a_stab_wait: assert property (relCnt_q < STAB_CYC |-> !sclOe && !sdaOe)
      else $error("link used before clock settled");
   a_attach_load: assert property ($rose(cfgLoaded) |-> ##[0:3] usbAttach)
      else $error("attach late after load");
   a_bus_power: assert property (usbBusReset [*5] |-> port_power_switch_ctl[3:2] == 2'h0)
      else $error("power bits 3:2 kept in bus reset");
   a_bus_state: assert property (usbBusReset [*5] |-> deviceAddress == 7'h00 && deviceConfig == 8'h00
      && !suspended)
      else $error("address, configuration or suspend kept in bus reset");
   a_no_forward: assert property ($rose(usbBusReset) |-> ##1 $stable(downstreamPortEn) [*6])
      else $error("bus reset reached downstream ports");
   a_tt_flush: assert property ($rose(usbBusReset) |-> ##[2:6] ttFlush)
      else $error("no buffer flush on bus reset");
   a_req_bound: assert property (reqBusy |-> busyCnt_q <= REQ_MAX_CYC + 2)
      else $error("request held past its limit");
endmodule : reset_seq_chk
bind reset_and_eeprom_config_sequencer reset_seq_chk #(.STAB_CYC(STAB_CYC), .REQ_MAX_CYC(REQ_MAX_CYC)) u_chk (.*);

/* File: test/eeprom_model.sv */
// Behavioural serial memory: acks its address, serves sequential reads.
// Assumes open-drain lines resolved outside with pull-ups.
`timescale 1ns/1ns
module eeprom_model #(
   parameter logic [6:0] DEV = 7'h50
) (
   input wire logic scl,
   input wire logic sda,
   input wire logic nackAll,
   output logic eeLow,
   output int nStarts,
   output int nStops,
   output int nRx,
   output logic [7:0] rxLog [0:7]
);
   // ==========================================================
   // Framing: a start resets the bit and byte counts
   logic [7:0] sh = 8'h00;
   logic [7:0] ptr = 8'h00;
   logic [7:0] dat;
   logic rdMode = 1'h0;
   int bitN = 0;
   int byteN = 0;
   initial begin
      eeLow = 1'h0;
      nStarts = 0;
      nStops = 0;
      nRx = 0;
   end
   always @(negedge sda) if (scl === 1'h1) begin
      nStarts++;
      bitN = 0;
      byteN = 0;
      rdMode = 1'h0;
   end
   always @(posedge sda) if (scl === 1'h1) nStops++;
   // Sample on clock rise; the ninth slot closes a byte
   always @(posedge scl) begin
      if (bitN < 8 && !rdMode) sh = {sh[6:0], sda};
      if (bitN == 8 && rdMode) begin
         rdMode = !sda;
         ptr++;
      end else if (bitN == 8) begin
         if (nRx < 8) rxLog[nRx] = sh;
         nRx++;
         if (byteN == 1) ptr = sh;
         rdMode = byteN == 0 && sh[0] && eeLow;
      end
      if (bitN == 8) byteN++;
      bitN = (bitN + 1) % 9;
   end
   // Drive changes only on a clock fall; released outside ack and read slots so a stop can pass
   always @(negedge scl) begin
      dat = {ptr[3:0], ~ptr[3:0]};
      if (bitN == 8 && !rdMode) eeLow = (byteN > 0 || sh[7:1] == DEV) && !nackAll;
      else if (rdMode && bitN < 8) eeLow = !dat[7 - bitN];
      else eeLow = 1'h0;
   end
endmodule : eeprom_model

/* File: test/reset_and_eeprom_config_sequencer_tb.sv */
// Testbench of the reset sequencer: power-on, bus reset, requests, pin reset, memory load.
// Assumes the memory model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module reset_and_eeprom_config_sequencer_tb;
   localparam int STAB = 20;
   localparam int REQMAX = 50;
   localparam int PMIN = 1000000000 / 70320;
   localparam int PMAX = 1000000000 / 46880;
   logic ref_clk = 1'h0, rst_n = 1'h0, external_hw_reset_low = 1'h1, usbBusReset = 1'h0;
   logic defaultCfgSel = 1'h1, nackAll = 1'h0, setAddrStrobe = 1'h0, setConfigStrobe = 1'h0;
   logic suspendReq = 1'h0, resumeReq = 1'h0, hostReqStart = 1'h0, hostReqDone = 1'h0;
   logic [3:0] portPowerReq = 4'h0, portEnableReq = 4'h0;
   logic [6:0] setAddrValue = 7'h00;
   logic [7:0] setConfigValue = 8'h00;
   logic sclOut, sclOe, sdaOut, sdaOe, cfgWrEn, cfgUseDefault, cfgLoaded, eeError, oscEnable;
   logic pllEnable, phyEnable, usbAttach, coreReset, suspended, ttFlush, reqBusy, reqForceDone, eeLow;
   logic [0:0] cfgWrAddr;
   logic [7:0] cfgWrData, deviceConfig;
   logic [3:0] port_power_switch_ctl, downstreamPortEn;
   logic [6:0] deviceAddress;
   logic [7:0] rxLog [0:7];
   logic [7:0] wrLog [0:7];
   logic [7:0] expData [0:1] = '{8'h0F, 8'h1E};
   int nStarts, nStops, nRx, n_fail = 0, compares = 0, cyc = 0, nWr = 0, nFlush = 0, minP, maxP, p;
   time lastRise = 0;
   wire scl = !sclOe;
   wire sda = !(sdaOe || eeLow);
   wire sdaIn = sda;
   reset_and_eeprom_config_sequencer #(.STAB_CYC(STAB), .LOAD_MAX_CYC(200000), .REQ_MAX_CYC(REQMAX),
      .CFG_BYTES(2)) u_dut (.*);
   eeprom_model u_mem (.*);
   // ==========================================================
   // Clock, watchdog and logs of the written bytes and flushes
   initial forever #4 ref_clk = !ref_clk;
   always @(posedge ref_clk) begin
      cyc++;
      if (cfgWrEn === 1'h1) begin
         chk("cfgWrAddr", cfgWrAddr, nWr[0:0]);
         wrLog[nWr[2:0]] = cfgWrData;
         nWr++;
      end
      if (ttFlush === 1'h1) nFlush++;
      if (cyc == 160000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   // Spacing of link clock rises; armed only once a load starts
   always @(posedge scl) begin
      p = int'($time - lastRise);
      if (lastRise != 0 && p < minP) minP = p;
      if (lastRise != 0 && p > maxP) maxP = p;
      lastRise = $time;
   end
   // ==========================================================
   // Shared tasks
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk
   task automatic cycles(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cycles
   task automatic pulse(ref logic s);
      s = 1'h1;
      cycles(1);
      s = 1'h0;
   endtask : pulse
   task automatic wait_hi(ref logic s, input int n);
      for (int i = 0; i < n && s !== 1'h1; i++) cycles(1);
   endtask : wait_hi
   task automatic tally_and_finish();
      $display("Compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   // ==========================================================
   // Scenarios
   task automatic t_por();
      chk("coreReset", coreReset, 1'h1);
      chk("oscEnable", oscEnable, 1'h0);
      rst_n = 1'h1;
      wait_hi(cfgLoaded, STAB + 100);
      cycles(3);
      chk("cfgUseDefault", cfgUseDefault, 1'h1);
      chk("usbAttach", usbAttach, 1'h1);
      chk("nStarts", nStarts, 0);
      $display("Test por done");
   endtask : t_por
   task automatic t_bus();
      portPowerReq = 4'hF;
      portEnableReq = 4'hF;
      setAddrValue = 7'h15;
      pulse(setAddrStrobe);
      setConfigValue = 8'h01;
      pulse(setConfigStrobe);
      pulse(suspendReq);
      cycles(3);
      chk("suspended", suspended, 1'h1);
      usbBusReset = 1'h1;
      cycles(8);
      chk("deviceAddress", deviceAddress, 7'h00);
      chk("deviceConfig", deviceConfig, 8'h00);
      chk("suspended", suspended, 1'h0);
      chk("powerCtl", port_power_switch_ctl, 4'h3);
      chk("portEn", downstreamPortEn, 4'hF);
      chk("nFlush", nFlush, 1);
      usbBusReset = 1'h0;
      cycles(6);
      chk("powerCtl", port_power_switch_ctl, 4'hF);
      $display("Test bus reset done");
   endtask : t_bus
   task automatic t_req();
      int i;
      pulse(hostReqStart);
      for (i = 0; i < 200 && reqForceDone !== 1'h1; i++) cycles(1);
      chk("forceDelay", i, REQMAX);
      pulse(hostReqStart);
      cycles(4);
      chk("reqBusy", reqBusy, 1'h1);
      pulse(hostReqDone);
      cycles(2);
      chk("reqBusy", reqBusy, 1'h0);
      $display("Test request done");
   endtask : t_req
   task automatic t_hw();
      setAddrValue = 7'h2A;
      pulse(setAddrStrobe);
      external_hw_reset_low = 1'h0;
      cycles(60);
      external_hw_reset_low = 1'h1;
      cycles(4);
      chk("shortPulse", {coreReset, deviceAddress}, 8'h2A);
      external_hw_reset_low = 1'h0;
      cycles(140);
      chk("clocks", {oscEnable, pllEnable, coreReset}, 3'h1);
      chk("phyEnable", phyEnable, 1'h0);
      chk("ports", {port_power_switch_ctl, downstreamPortEn}, 8'h00);
      chk("regs", {deviceAddress, usbAttach, cfgLoaded}, 9'h000);
      chk("linkOe", {sclOe, sdaOe}, 2'h0);
      defaultCfgSel = 1'h0;
      cycles(60);
      external_hw_reset_low = 1'h1;
      $display("Test pin reset done");
   endtask : t_hw
   task automatic t_abort();
      cycles(STAB + 2000);
      chk("started", nStarts > 0, 1'h1);
      external_hw_reset_low = 1'h0;
      cycles(6);
      chk("linkOe", {sclOe, sdaOe}, 2'h0);
      cycles(194);
      chk("aborted", {nWr[3:0], cfgLoaded}, 5'h00);
      external_hw_reset_low = 1'h1;
      $display("Test abort done");
   endtask : t_abort
   task automatic t_load();
      int s0, p0;
      s0 = nStarts;
      p0 = nStops;
      minP = 1000000000;
      maxP = 0;
      lastRise = 0;
      wait_hi(cfgLoaded, 200000);
      cycles(4);
      chk("nWr", nWr, 2);
      for (int i = 0; i < 2; i++) chk("cfgWrData", wrLog[i], expData[i]);
      chk("writeAddr", rxLog[0], 8'hA0);
      chk("wordAddr", rxLog[1], 8'h00);
      chk("readAddr", rxLog[2], 8'hA1);
      chk("starts", nStarts - s0, 2);
      chk("stops", nStops - p0, 1);
      chk("status", {eeError, cfgUseDefault}, 2'h0);
      chk("sclFast", minP >= PMIN, 1'h1);
      chk("sclSlow", maxP <= PMAX, 1'h1);
      $display("Test load done");
   endtask : t_load
   task automatic t_nack();
      int p0;
      p0 = nStops;
      nackAll = 1'h1;
      external_hw_reset_low = 1'h0;
      cycles(200);
      external_hw_reset_low = 1'h1;
      wait_hi(eeError, 40000);
      cycles(4);
      chk("eeError", eeError, 1'h1);
      chk("cfgUseDefault", cfgUseDefault, 1'h1);
      chk("stops", nStops - p0, 1);
      chk("linkOe", {sclOe, sdaOe, sclOut, sdaOut}, 4'h0);
      $display("Test nack done");
   endtask : t_nack
   initial begin
      cycles(20);
      t_por();
      t_bus();
      t_req();
      t_hw();
      t_abort();
      t_load();
      t_nack();
      tally_and_finish();
   end
endmodule : reset_and_eeprom_config_sequencer_tb
